// ### hdl/fdc_cmd_decode.sv
`timescale 1ns/10ps
module fdc_cmd_decode (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output logic [7:0] result_byte,
    output logic result_valid,
    input wire logic result_ready,
    output logic busy,
    input wire logic xfer_start,
    input wire logic [7:0] xfer_cylinder,
    input wire logic [1:0] xfer_drive,
    output logic xfer_seek_done,
    output logic xfer_seek_fail,
    input wire logic last_was_format,
    input wire logic [7:0] sectors_per_cylinder,
    input wire logic [7:0] end_of_track_sector,
    input wire logic track0_pin,
    input wire logic write_protect_pin,
    input wire logic id_found_pin,
    input wire logic [31:0] id_data,
    output logic step_pulse,
    output logic step_direction,
    output logic head_side,
    output logic standby
);
    // Pin synchronisers; first stage read only by second
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end
        else
        begin
            pin_meta <= {id_found_pin, write_protect_pin, track0_pin};
            pin_sync <= pin_meta;
        end
    end

    fdc_cmd_pkg::state_t state;
    logic [7:0] opcode;
    logic [3:0] pcount;
    logic [3:0] rcount;
    logic [3:0] rtotal;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
    logic [7:0] cyl [0:3]; // Present cylinder per drive
    logic [7:0] step_rate_time_hut;
    logic [7:0] head_load_time_nd;
    logic [7:0] cfg_b2; // Implied seek, fifo flags, threshold
    logic [7:0] precomp_start_track;
    logic [7:0] perp;
    logic lock_flag;
    logic [7:0] target;
    logic [1:0] sel_drive; // Internal only, never a pin
    logic implied;
    logic [12:0] timer;
    logic [31:0] id_cap;
    logic [7:0] st0;

    // Opcode decode
    // opcode decode table
    wire is_specify = cmd_byte == fdc_cmd_pkg::op_specify;
    wire is_sense = cmd_byte == fdc_cmd_pkg::op_sense_drive;
    wire is_seek = cmd_byte == fdc_cmd_pkg::op_seek;
    wire is_cfg = cmd_byte == fdc_cmd_pkg::op_configure;
    wire is_dump = cmd_byte == fdc_cmd_pkg::op_dump;
    wire is_rid = cmd_byte[4:0] == fdc_cmd_pkg::op_read_id && cmd_byte[7] == 1'b0
        && cmd_byte[5] == 1'b0;
    wire is_perp = cmd_byte == fdc_cmd_pkg::op_perpendicular;
    wire is_lock = cmd_byte[6:0] == fdc_cmd_pkg::op_lock;
    wire is_rseek = cmd_byte[7] && cmd_byte[5:0] == fdc_cmd_pkg::op_rel_seek;
    wire known = is_specify | is_sense | is_seek | is_cfg | is_dump | is_rid
        | is_perp | is_lock | is_rseek;
    // Parameter bytes still to come after the first
    wire [3:0] nparams = (is_specify | is_rseek | is_seek) ? 4'h2 : is_cfg ? 4'h3
        : (is_sense | is_rid | is_perp) ? 4'h1 : 4'h0;
    // Decode flags for the held opcode, used after the first byte
    wire op_rseek = opcode[7] && opcode[5:0] == fdc_cmd_pkg::op_rel_seek;
    wire op_sense = opcode == fdc_cmd_pkg::op_sense_drive;
    wire op_rid = opcode[4:0] == fdc_cmd_pkg::op_read_id && !opcode[7];
    wire op_dump = opcode == fdc_cmd_pkg::op_dump;
    wire op_lock = opcode[6:0] == fdc_cmd_pkg::op_lock;
    wire [7:0] cur_cyl = cyl[sel_drive];
    // Cylinder of the drive named in the command, before sel_drive is loaded
    wire [7:0] exec_cyl = cyl[p2[1:0]];
    // Relative target wraps within eight bits; the step count is the last byte
    wire [7:0] rel_target = opcode[fdc_cmd_pkg::dir_bit] ? 8'(exec_cyl + p3)
        : 8'(exec_cyl - p3);
    // Status register three assembly
    // drive status byte
    wire [7:0] st3 = {1'b0, pin_sync[1], 1'b1, pin_sync[0], 1'b1, p1[2], p1[1:0]};
    // count or end sector by last command
    wire [7:0] sc_eot = last_was_format ? sectors_per_cylinder : end_of_track_sector;
    wire [4:0] rindex = 5'(rcount);
    logic [7:0] rbyte;
    always_comb
    begin
        rbyte = fdc_cmd_pkg::reset_byte;
        if (op_sense)
            rbyte = st3;
        else if (op_dump)
        begin
            case (rindex)
                5'h00, 5'h01, 5'h02, 5'h03: rbyte = cyl[rindex[1:0]];
                5'h04: rbyte = step_rate_time_hut;
                5'h05: rbyte = head_load_time_nd;
                5'h06: rbyte = sc_eot;
                5'h07: rbyte = {lock_flag, 1'b0, perp[5:0]};
                5'h08: rbyte = cfg_b2;
                5'h09: rbyte = precomp_start_track;
                default: rbyte = fdc_cmd_pkg::reset_byte;
            endcase
        end
        else if (op_lock)
            rbyte = 8'(lock_flag) << fdc_cmd_pkg::lock_result_bit;
        else if (op_rid)
        begin
            case (rindex)
                5'h00: rbyte = st0;
                5'h01, 5'h02: rbyte = fdc_cmd_pkg::reset_byte;
                5'h03: rbyte = id_cap[31:24];
                5'h04: rbyte = id_cap[23:16];
                5'h05: rbyte = id_cap[15:8];
                5'h06: rbyte = id_cap[7:0];
                default: rbyte = fdc_cmd_pkg::reset_byte;
            endcase
        end
        else
            rbyte = st0;
    end

    assign cmd_ready = state == fdc_cmd_pkg::st_idle || state == fdc_cmd_pkg::st_params;
    assign result_valid = state == fdc_cmd_pkg::st_result;
    assign busy = state != fdc_cmd_pkg::st_idle;
    // head side from internal select, no drive pins
    assign head_side = p1[2];

    // Main sequencer; long but each branch is one command phase
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= fdc_cmd_pkg::st_idle;
            opcode <= fdc_cmd_pkg::reset_byte;
            pcount <= 4'h0;
            rcount <= 4'h0;
            rtotal <= 4'h0;
            p1 <= fdc_cmd_pkg::reset_byte;
            p2 <= fdc_cmd_pkg::reset_byte;
            p3 <= fdc_cmd_pkg::reset_byte;
            for (int i = 0; i < 4; i++)
                cyl[i] <= fdc_cmd_pkg::reset_byte;
            step_rate_time_hut <= fdc_cmd_pkg::reset_byte;
            head_load_time_nd <= fdc_cmd_pkg::reset_byte;
            cfg_b2 <= fdc_cmd_pkg::reset_cfg;
            precomp_start_track <= fdc_cmd_pkg::reset_byte;
            perp <= fdc_cmd_pkg::reset_byte;
            lock_flag <= 1'b0;
            target <= fdc_cmd_pkg::reset_byte;
            sel_drive <= 2'h0;
            implied <= 1'b0;
            timer <= 13'h0;
            id_cap <= 32'h0;
            st0 <= fdc_cmd_pkg::reset_byte;
            result_byte <= fdc_cmd_pkg::reset_byte;
            step_pulse <= 1'b0;
            step_direction <= 1'b0;
            standby <= 1'b0;
            xfer_seek_done <= 1'b0;
            xfer_seek_fail <= 1'b0;
        end
        else
        begin
            step_pulse <= 1'b0;
            xfer_seek_done <= 1'b0;
            xfer_seek_fail <= 1'b0;
            result_byte <= rbyte;
            case (state)
                fdc_cmd_pkg::st_idle:
                begin
                    if (cmd_valid)
                    begin
                        opcode <= cmd_byte;
                        pcount <= nparams;
                        rcount <= 4'h0;
                        standby <= 1'b0;
                        if (!known)
                        begin
                            st0 <= fdc_cmd_pkg::invalid_status;
                            standby <= 1'b1;
                            rtotal <= 4'h1;
                            state <= fdc_cmd_pkg::st_result;
                        end
                        else if (nparams == 4'h0)
                            state <= fdc_cmd_pkg::st_exec;
                        else
                            state <= fdc_cmd_pkg::st_params;
                    end
                    else if (xfer_start && cfg_b2[6])
                    begin
                        implied <= 1'b1;
                        sel_drive <= xfer_drive;
                        target <= xfer_cylinder;
                        timer <= 13'h0;
                        state <= fdc_cmd_pkg::st_seek;
                    end
                    else if (xfer_start)
                        xfer_seek_done <= 1'b1;
                end
                fdc_cmd_pkg::st_params:
                begin
                    if (cmd_valid)
                    begin
                        // Bytes shift in so the last lands in p3
                        p1 <= p2;
                        p2 <= p3;
                        p3 <= cmd_byte;
                        pcount <= pcount - 4'h1;
                        if (pcount == 4'h1)
                            state <= fdc_cmd_pkg::st_exec;
                    end
                end
                fdc_cmd_pkg::st_exec:
                begin
                    rtotal <= 4'h0;
                    state <= fdc_cmd_pkg::st_idle;
                    timer <= 13'h0;
                    implied <= 1'b0;
                    if (opcode == fdc_cmd_pkg::op_specify)
                    begin
                        step_rate_time_hut <= p2;
                        head_load_time_nd <= p3;
                    end
                    else if (op_sense)
                    begin
                        // Sense: the single drive byte sits in p3
                        p1 <= p3;
                        rtotal <= 4'h1;
                        state <= fdc_cmd_pkg::st_result;
                    end
                    else if (opcode == fdc_cmd_pkg::op_seek || op_rseek)
                    begin
                        p1 <= p2;
                        sel_drive <= p2[1:0];
                        target <= opcode == fdc_cmd_pkg::op_seek ? p3 : rel_target;
                        state <= fdc_cmd_pkg::st_seek;
                    end
                    else if (opcode == fdc_cmd_pkg::op_configure)
                    begin
                        cfg_b2 <= p2;
                        precomp_start_track <= p3;
                    end
                    else if (op_dump)
                    begin
                        rtotal <= fdc_cmd_pkg::max_result;
                        state <= fdc_cmd_pkg::st_result;
                    end
                    else if (op_rid)
                    begin
                        p1 <= p3;
                        sel_drive <= p3[1:0];
                        state <= fdc_cmd_pkg::st_read_id;
                    end
                    else if (opcode == fdc_cmd_pkg::op_perpendicular)
                        perp <= p3;
                    else if (op_lock)
                    begin
                        lock_flag <= opcode[fdc_cmd_pkg::lock_bit];
                        rtotal <= 4'h1;
                        state <= fdc_cmd_pkg::st_result;
                    end
                end
                fdc_cmd_pkg::st_seek:
                begin
                    timer <= 13'(timer + 13'h1);
                    if (cur_cyl == target)
                    begin
                        st0 <= {2'b00, 1'b1, 2'b00, p1[2], sel_drive};
                        xfer_seek_done <= implied;
                        implied <= 1'b0;
                        state <= fdc_cmd_pkg::st_idle;
                    end
                    else if (cur_cyl > target && pin_sync[0])
                    begin
                        // Track zero reached short of target: fail
                        st0 <= {2'b01, 1'b1, 1'b1, 1'b0, p1[2], sel_drive};
                        xfer_seek_fail <= implied;
                        implied <= 1'b0;
                        state <= fdc_cmd_pkg::st_idle;
                    end
                    else if (timer >= 13'(fdc_cmd_pkg::step_cycles))
                    begin
                        timer <= 13'h0;
                        step_pulse <= 1'b1;
                        step_direction <= target > cur_cyl;
                        cyl[sel_drive] <= target > cur_cyl ? 8'(cur_cyl + 8'h1)
                            : 8'(cur_cyl - 8'h1);
                    end
                end
                fdc_cmd_pkg::st_read_id:
                begin
                    timer <= 13'(timer + 13'h1);
                    rtotal <= 4'h7;
                    if (pin_sync[2])
                    begin
                        id_cap <= id_data;
                        st0 <= {5'h0, p1[2], sel_drive};
                        state <= fdc_cmd_pkg::st_result;
                    end
                    else if (timer >= 13'(fdc_cmd_pkg::id_wait_cycles))
                    begin
                        st0 <= {2'b01, 3'h0, p1[2], sel_drive};
                        state <= fdc_cmd_pkg::st_result;
                    end
                end
                fdc_cmd_pkg::st_result:
                begin
                    if (result_ready)
                    begin
                        rcount <= rcount + 4'h1;
                        if (rcount + 4'h1 >= rtotal)
                            state <= fdc_cmd_pkg::st_idle;
                    end
                end
                default: state <= fdc_cmd_pkg::st_idle;
            endcase
        end
    end

    // Checks
    // result_byte lags one cycle, so check state-side causes
    chk_invalid_status: assert property (@(posedge clock) disable iff (rst)
        (state == fdc_cmd_pkg::st_idle && cmd_valid && !known)
        |=> (st0 == fdc_cmd_pkg::invalid_status && standby && rtotal == 4'h1))
        else $error("invalid opcode not answered with 80h");
    chk_seek_reaches: assert property (@(posedge clock) disable iff (rst)
        (state == fdc_cmd_pkg::st_seek && cur_cyl == target) |=> state == fdc_cmd_pkg::st_idle)
        else $error("seek did not finish at target");
    chk_sense_one: assert property (@(posedge clock) disable iff (rst)
        (state == fdc_cmd_pkg::st_exec && op_sense) |=> rtotal == 4'h1)
        else $error("sense drive result count wrong");
    chk_rid_capture: assert property (@(posedge clock) disable iff (rst)
        (state == fdc_cmd_pkg::st_read_id && pin_sync[2]) |=> id_cap == $past(id_data))
        else $error("identifier not captured");
    chk_dump_sceot: assert property (@(posedge clock) disable iff (rst)
        (state == fdc_cmd_pkg::st_result && op_dump && rindex == 5'h06)
        |=> result_byte == (last_was_format ? sectors_per_cylinder : end_of_track_sector))
        else $error("dump count or end sector wrong");
    chk_implied_seek: assert property (@(posedge clock) disable iff (rst)
        (state == fdc_cmd_pkg::st_idle && !cmd_valid && xfer_start && cfg_b2[6])
        |=> state == fdc_cmd_pkg::st_seek)
        else $error("implied seek not started");
    chk_step_dir: assert property (@(posedge clock) disable iff (rst)
        step_pulse |-> step_direction == (target > $past(cur_cyl)))
        else $error("step direction wrong");
    chk_lock_result: assert property (@(posedge clock) disable iff (rst)
        (state == fdc_cmd_pkg::st_exec && op_lock) |=> lock_flag == $past(opcode[7]))
        else $error("lock flag not taken from opcode");
endmodule : fdc_cmd_decode

// ### hdl/fdc_cmd_pkg.sv
package fdc_cmd_pkg;
    // First-byte opcodes, compared on all eight bits except read identifier, lock and relative seek
    localparam logic [7:0] op_specify = 8'h03;
    localparam logic [7:0] op_sense_drive = 8'h04;
    localparam logic [7:0] op_seek = 8'h0f;
    localparam logic [7:0] op_configure = 8'h13;
    localparam logic [7:0] op_dump = 8'h0e;
    localparam logic [4:0] op_read_id = 5'h0a;
    localparam logic [7:0] op_perpendicular = 8'h12;
    localparam logic [6:0] op_lock = 7'h14;
    localparam logic [5:0] op_rel_seek = 6'h0f;
    // Result for an unknown opcode
    localparam logic [7:0] invalid_status = 8'h80;
    // Bit positions
    localparam int mfm_bit = 6;
    localparam int lock_bit = 7;
    localparam int dir_bit = 6;
    localparam int lock_result_bit = 4;
    // Reset values
    localparam logic [7:0] reset_cfg = 8'h20;
    localparam logic [7:0] reset_byte = 8'h00;
    // Step pulse spacing, in ns and then in cycles
    localparam int step_time_ns = 1000;
    localparam int step_cycles = (step_time_ns + 9) / 10;
    // Timeout waiting for an identifier, in cycles
    localparam int id_wait_cycles = 4000;
    // Largest result count
    localparam logic [3:0] max_result = 4'ha;
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_params = 3'b001,
        st_exec = 3'b010,
        st_seek = 3'b011,
        st_read_id = 3'b100,
        st_result = 3'b101
    } state_t;
endpackage : fdc_cmd_pkg

// ### tb/disk_drive_model.sv
`timescale 1ns/10ps
// Behavioural disk drive: head position, track zero and identifier stream
module disk_drive_model #(
    parameter logic write_protect = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic step_pulse,
    input wire logic step_direction,
    output logic track0_pin,
    output logic write_protect_pin,
    output logic id_found_pin,
    output logic [31:0] id_data,
    output logic [7:0] cylinder
);
    // Short revolution so that identifier searches stay quick
    logic [5:0] phase;
    // Previous step level, so a wide pulse still counts once
    logic step_prev;
    // Identifier under the head: cylinder, head 1, sector 7, size code 2
    logic [31:0] id_word;
    assign id_word = {cylinder, 8'h01, 8'h07, 8'h02};
    // Head follows step edges and stops at the mechanical limit
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cylinder <= 8'h00;
            phase <= 6'h00;
            step_prev <= 1'b0;
        end
        else
        begin
            phase <= phase + 6'h01;
            step_prev <= step_pulse;
            if (step_pulse && !step_prev && step_direction)
                cylinder <= cylinder + 8'h01;
            else if (step_pulse && !step_prev && cylinder != 8'h00)
                cylinder <= cylinder - 8'h01;
        end
    end
    // Found for 8 cycles; data held 10 more, then inverted as a stale bus
    assign id_found_pin = (phase >= 6'd10) && (phase < 6'd18);
    assign id_data = ((phase >= 6'd10) && (phase < 6'd28)) ? id_word : ~id_word;
    assign track0_pin = (cylinder == 8'h00);
    assign write_protect_pin = write_protect;
endmodule : disk_drive_model

// ### tb/floppy_cmd_decode_config_test.sv
`timescale 1ns/10ps
// Self-checking bench for the setup and positioning command interpreter
module floppy_cmd_decode_config_test;
    logic clock, rst, cmd_valid, cmd_ready, result_valid, result_ready, busy;
    logic xfer_start, xfer_seek_done, xfer_seek_fail, last_was_format, standby;
    logic track0_pin, write_protect_pin, id_found_pin, step_pulse, step_direction, head_side;
    logic [7:0] cmd_byte, result_byte, xfer_cylinder, cylinder, got;
    logic [1:0] xfer_drive;
    logic [31:0] id_data;
    logic [7:0] bad_codes [3] = '{8'h00, 8'h1f, 8'h55};
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    fdc_cmd_decode DUT (.clock(clock), .rst(rst), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .result_byte(result_byte), .result_valid(result_valid),
        .result_ready(result_ready), .busy(busy), .xfer_start(xfer_start),
        .xfer_cylinder(xfer_cylinder), .xfer_drive(xfer_drive), .xfer_seek_done(xfer_seek_done),
        .xfer_seek_fail(xfer_seek_fail), .last_was_format(last_was_format),
        .sectors_per_cylinder(8'h12), .end_of_track_sector(8'h09), .track0_pin(track0_pin),
        .write_protect_pin(write_protect_pin), .id_found_pin(id_found_pin), .id_data(id_data),
        .step_pulse(step_pulse), .step_direction(step_direction), .head_side(head_side),
        .standby(standby));
    disk_drive_model drive (.clock(clock), .rst(rst), .step_pulse(step_pulse),
        .step_direction(step_direction), .track0_pin(track0_pin),
        .write_protect_pin(write_protect_pin), .id_found_pin(id_found_pin), .id_data(id_data),
        .cylinder(cylinder));
    // Free-running 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // One edge, then the usual small drive delay
    task automatic tick;
        @(posedge clock);
        #1;
    endtask : tick
    // Compare and count
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : check8
    // Command bytes back to back, valid held until each is taken
    task automatic send_cmd(input logic [7:0] bytes [$]);
        cmd_valid = 1'b1;
        foreach (bytes[i])
        begin
            cmd_byte = bytes[i];
            // Watchdog bounds every wait
            while (cmd_ready !== 1'b1)
                tick();
            tick();
        end
        cmd_valid = 1'b0;
        tick();
    endtask : send_cmd
    // Result byte lags valid by one edge, so sample after one more edge
    task automatic read_byte(output logic [7:0] b);
        while (result_valid !== 1'b1)
            tick();
        tick();
        b = result_byte;
        result_ready = 1'b1;
        tick();
        result_ready = 1'b0;
    endtask : read_byte
    // Whole result phase, then the interpreter must be idle again
    task automatic expect_res(input string what, input logic [7:0] exp [$]);
        foreach (exp[i])
        begin
            read_byte(got);
            check8(what, exp[i], got);
        end
        check8("busy after results", 8'h00, {7'h00, busy});
    endtask : expect_res
    // Wait for a seek to finish; a hang ends at the watchdog as a failure
    task automatic wait_idle;
        while (busy !== 1'b0)
            tick();
    endtask : wait_idle
    // Counts, verdict, end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    // Watchdog: a hung handshake ends as a failure
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            close_out();
        end
    end
    // Main sequence; drive select 01 throughout, head bit set only in the second sense drive status
    initial
    begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        result_ready = 1'b0;
        xfer_start = 1'b0;
        xfer_cylinder = 8'h00;
        xfer_drive = 2'b01;
        last_was_format = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        rst = 1'b0;
        foreach (bad_codes[i])
        begin
            send_cmd('{bad_codes[i]});
            expect_res("invalid status", '{8'h80});
            check8("standby", 8'h01, {7'h00, standby});
        end
        send_cmd('{8'h0e});
        expect_res("dump reset", '{0, 0, 0, 0, 0, 0, 8'h09, 0, 8'h20, 0});
        check8("standby cleared", 8'h00, {7'h00, standby});
        // implied seek off: transfer released at once
        xfer_start = 1'b1;
        tick();
        xfer_start = 1'b0;
        check8("no implied seek", 8'h01, {7'h00, xfer_seek_done});
        send_cmd('{8'h03, 8'ha5, 8'h3c});
        send_cmd('{8'h13, 8'h00, 8'h4a, 8'h07});
        send_cmd('{8'h12, 8'h2b});
        send_cmd('{8'h94});
        expect_res("lock set", '{8'h10});
        send_cmd('{8'h0f, 8'h01, 8'h05});
        wait_idle();
        check8("cylinder after seek", 8'h05, cylinder);
        send_cmd('{8'hcf, 8'h01, 8'h03});
        wait_idle();
        check8("cylinder after step in", 8'h08, cylinder);
        send_cmd('{8'h8f, 8'h01, 8'h02});
        wait_idle();
        check8("cylinder after step out", 8'h06, cylinder);
        for (int h = 0; h < 2; h++)
        begin
            send_cmd('{8'h04, {5'h00, h[0], 2'b01}});
            read_byte(got);
            check8("drive status", {5'b00101, h[0], 2'b01}, got);
            check8("head side", {7'h00, h[0]}, {7'h00, head_side});
            check8("busy after status", 8'h00, {7'h00, busy});
        end
        last_was_format = 1'b1;
        send_cmd('{8'h0e});
        expect_res("dump format", '{0, 6, 0, 0, 8'ha5, 8'h3c, 8'h12, 8'hab, 8'h4a, 7});
        send_cmd('{8'h14});
        expect_res("lock clear", '{8'h00});
        last_was_format = 1'b0;
        send_cmd('{8'h0e});
        expect_res("dump transfer", '{0, 6, 0, 0, 8'ha5, 8'h3c, 8'h09, 8'h2b, 8'h4a, 7});
        xfer_cylinder = 8'h09;
        xfer_start = 1'b1;
        tick();
        xfer_start = 1'b0;
        while (xfer_seek_done !== 1'b1)
            tick();
        check8("implied seek done", 8'h01, {7'h00, xfer_seek_done});
        check8("implied seek fail", 8'h00, {7'h00, xfer_seek_fail});
        check8("cylinder after implied seek", 8'h09, cylinder);
        send_cmd('{8'h4a, 8'h01});
        read_byte(got);
        check8("identifier status drive", 8'h01, {6'h00, got[1:0]});
        expect_res("identifier", '{0, 0, 8'h09, 8'h01, 8'h07, 8'h02});
        close_out();
    end
endmodule : floppy_cmd_decode_config_test
